// File: dv/sram_bus_master.sv
// bus master model driving one port's pins
`timescale 1ns/1ps
`default_nettype none
module sram_bus_master
  import sram_port_pkg::*;
(
  input wire logic clk,
  output port_in_s pin
);
  initial pin = {17'h1ffff, 9'h1ff, 7'h6e};
  task automatic put(input port_in_s v);
    @(posedge clk);
    pin <= v;
  endtask : put
endmodule : sram_bus_master
`default_nettype wire

// File: dv/sram_port_sva.sv
// assertions on port 0 of the ram port logic
`timescale 1ns/1ps
`default_nettype none
module sram_port_sva
  import sram_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire port_in_s port_in [PORTS],
  input wire logic [PORTS-1:0] output_enable_n,
  input wire port_out_s port_out [PORTS]
);
  wire port_in_s i = port_in[0];
  wire port_out_s o = port_out[0];
  wire s = !i.select_active_low && i.select_active_high;
  wire r = i.read_not_write;
  wire f = !i.output_latency_select;
  wire h = i.address_load_strobe_n && i.counter_advance_n && i.counter_clear_n;
  wire e = output_enable_n[0];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  oe_async_a: assert property (e |-> o.data_oe_n) else $error("oe");
  flow_drive_a: assert property (s && r && f ##1 f && !e |-> !o.data_oe_n) else $error("flow");
  deselect_hiz_a: assert property (!s |=> o.data_oe_n) else $error("desel");
  write_hiz_a: assert property (s && !r |=> o.data_oe_n) else $error("write");
  pipe_wait_a: assert property (!s ##1 s && r && !f |=> o.data_oe_n) else $error("wait");
  pipe_drive_a: assert property (s && r && !f ##1 s && r && !f |=> o.data_oe_n == e) else $error("pipe");
  hold_data_a: assert property (s && r && f ##1 s && r && f && h |=> $stable(o.rdata)) else $error("hold");
  clear_zero_a: assert property (s && !r && !i.counter_clear_n ##1 s && r && f && h
    |=> o.rdata == $past(i.wdata, 2)) else $error("clear");
endmodule : sram_port_sva
bind dual_port_sync_sram_port sram_port_sva sva_u (.clk(clk), .rst(rst), .port_in(port_in),
  .output_enable_n(output_enable_n), .port_out(port_out));
`default_nettype wire

// File: dv/tb.sv
// self-checking bench for the ram port logic
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sram_port_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [PORTS-1:0] oe_n = 2'h0;
  port_in_s pin [PORTS];
  port_out_s pout [PORTS];
  wire port_out_s q = pout[0];
  int errors = 0;
  int total_checks = 0;
  always #2.5 clk = ~clk;
  sram_bus_master m0 (.clk(clk), .pin(pin[0]));
  sram_bus_master m1 (.clk(clk), .pin(pin[1]));
  dual_port_sync_sram_port dut_u (.clk(clk), .rst(rst), .port_in(pin), .output_enable_n(oe_n), .port_out(pout));
  // m is read, load_n, advance_n, clear_n, latency
  function automatic port_in_s c(input logic [16:0] a, input logic [8:0] d, input logic [4:0] m);
    return {a, d, m[4], 2'h1, m[3:0]};
  endfunction : c
  function automatic port_in_s d(input logic l);
    return {17'h1ffff, 9'h1ff, 6'h37, l};
  endfunction : d
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic go(input port_in_s v);
    m0.put(v);
    #1;
  endtask : go
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    go(c(17'h5, 9'h1a5, 5'h06));
    go(c(17'h5, 9'h0, 5'h16));
    chk(q.data_oe_n, 1'b1);
    go(c(17'h0, 9'h0, 5'h1e));
    chk(q.rdata, 9'h1a5);
    chk(q.data_oe_n, 1'b0);
    go(d(1'b0));
    chk(q.rdata, 9'h1a5);
    go(d(1'b0));
    chk(q.data_oe_n, 1'b1);
    $display("basic");
    go(c(17'h8, 9'h011, 5'h06));
    go(c(17'h0, 9'h022, 5'h0a));
    go(c(17'h9, 9'h0, 5'h16));
    go(c(17'h8, 9'h0, 5'h16));
    chk(q.rdata, 9'h022);
    go(d(1'b0));
    chk(q.rdata, 9'h011);
    $display("burst");
    go(c(17'h7, 9'h033, 5'h06));
    go(c(17'h7, 9'h0cc, 5'h04));
    go(c(17'h7, 9'h0, 5'h1e));
    go(c(17'h7, 9'h0, 5'h16));
    chk(q.rdata, 9'h0cc);
    go(d(1'b0));
    chk(q.rdata, 9'h033);
    $display("clear");
    m1.put(c(17'h3, 9'h155, 5'h06));
    m1.put(d(1'b0));
    go(c(17'h3, 9'h0, 5'h16));
    go(d(1'b0));
    chk(q.rdata, 9'h155);
    m1.put(c(17'h5, 9'h0, 5'h16));
    m1.put(d(1'b0));
    #1 chk(pout[1].rdata, 9'h1a5);
    chk(pout[1].data_oe_n, 1'b0);
    $display("port1");
    go(c(17'h6, 9'h0, 5'h16));
    go(d(1'b0));
    go(c(17'h6, 9'h0aa, 5'h06));
    go(c(17'h6, 9'h0, 5'h16));
    go(d(1'b0));
    chk(q.rdata, 9'h0aa);
    $display("turnaround");
    go(c(17'h5, 9'h0, 5'h17));
    go(c(17'h5, 9'h0, 5'h17));
    chk(q.data_oe_n, 1'b1);
    go(d(1'b1));
    chk(q.rdata, 9'h1a5);
    chk(q.data_oe_n, 1'b0);
    oe_n[0] <= 1'b1;
    #1 chk(q.data_oe_n, 1'b1);
    oe_n[0] <= 1'b0;
    $display("pipe");
    wrap_up;
  end
  initial begin
    #2000;
    errors++;
    wrap_up;
  end
endmodule : tb
`default_nettype wire

// File: rtl/dual_port_sync_sram_port.sv
// synchronous port logic of a dual-port static ram: counters, output timing, selects
`timescale 1ns/1ps
`default_nettype none
module dual_port_sync_sram_port
  import sram_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire port_in_s port_in [PORTS],
  input wire logic [PORTS-1:0] output_enable_n,
  output port_out_s port_out [PORTS]
);

  logic [PORTS-1:0] write_en;
  logic [ADDR_W-1:0] access_addr [PORTS];
  logic [DATA_W-1:0] write_data [PORTS];
  logic [DATA_W-1:0] array_rdata [PORTS];

  // ----------------------------------------------------------------
  // shared array
  // ----------------------------------------------------------------
  shared_array u_array (
    .clk(clk),
    .write_en(write_en),
    .addr(access_addr),
    .wdata(write_data),
    .rdata(array_rdata)
  );

  // ----------------------------------------------------------------
  // per-port logic
  // ----------------------------------------------------------------
  for (genvar g = 0; g < PORTS; g++) begin : gen_port
    logic selected;
    logic [ADDR_W-1:0] counter;
    logic [ADDR_W-1:0] next_counter;
    logic sel_q;
    logic next_sel_q;
    logic rd_q;
    logic next_rd_q;
    logic stage1;
    logic next_stage1;
    logic stage2;
    logic next_stage2;
    logic [DATA_W-1:0] stage2_data;
    logic [DATA_W-1:0] next_stage2_data;
    logic drive;

    // --------------------------------------------------------------
    // select decode
    // --------------------------------------------------------------
    // both selects must agree, so a bank needs no decoder
    assign selected = !port_in[g].select_active_low && port_in[g].select_active_high;

    // --------------------------------------------------------------
    // address counter
    // --------------------------------------------------------------
    // clear wins over load, load over advance; the counter follows the
    // access address even while the port is deselected
    always_comb begin
      if (!port_in[g].counter_clear_n) begin
        access_addr[g] = LOCATION_ZERO;
      end else if (!port_in[g].address_load_strobe_n) begin
        access_addr[g] = port_in[g].addr;
      end else if (!port_in[g].counter_advance_n) begin
        access_addr[g] = counter + COUNTER_STEP;
      end else begin
        access_addr[g] = counter;
      end
      next_counter = access_addr[g];
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        counter <= LOCATION_ZERO;
      end else begin
        counter <= next_counter;
      end
    end

    // --------------------------------------------------------------
    // write path
    // --------------------------------------------------------------
    // the write goes to the same address the read would use, so an
    // advance or a clear in this cycle steers the write as well
    always_comb begin
      write_en[g] = selected && !port_in[g].read_not_write;
      write_data[g] = port_in[g].wdata;
    end

    // --------------------------------------------------------------
    // control pipeline
    // --------------------------------------------------------------
    // remembers what the last two edges asked for; the output state of a
    // cycle is decided by these bits plus the live latency select and enable pins
    always_comb begin
      next_sel_q = selected;
      next_rd_q = port_in[g].read_not_write;
      next_stage1 = selected && port_in[g].read_not_write;
      next_stage2 = stage1;
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        sel_q <= 1'b0;
        rd_q <= 1'b0;
        stage1 <= 1'b0;
        stage2 <= 1'b0;
      end else begin
        sel_q <= next_sel_q;
        rd_q <= next_rd_q;
        stage1 <= next_stage1;
        stage2 <= next_stage2;
      end
    end

    // --------------------------------------------------------------
    // pipelined data stage
    // --------------------------------------------------------------
    // only a selected read refreshes the extra stage, so idle cycles
    // leave the last word standing
    always_comb begin
      next_stage2_data = stage1 ? array_rdata[g] : stage2_data;
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        stage2_data <= DATA_RESET;
      end else begin
        stage2_data <= next_stage2_data;
      end
    end

    // --------------------------------------------------------------
    // output timing
    // --------------------------------------------------------------
    // pipelined drive needs two selected read edges; deselect acts after one
    assign drive = port_in[g].output_latency_select ? (stage2 && sel_q && rd_q) : stage1;
    // a read of a cell written by the other port on the same edge returns old data
    assign port_out[g].rdata = port_in[g].output_latency_select ? stage2_data : array_rdata[g];
    // the enable pin bypasses every register so a shared bus can release at once
    assign port_out[g].data_oe_n = !(drive && !output_enable_n[g]);
  end

endmodule : dual_port_sync_sram_port
`default_nettype wire

// File: rtl/shared_array.sv
// shared storage array with one write and one registered read per port
`timescale 1ns/1ps
`default_nettype none
module shared_array
  import sram_port_pkg::*;
(
  input wire logic clk,
  input wire logic [PORTS-1:0] write_en,
  input wire logic [ADDR_W-1:0] addr [PORTS],
  input wire logic [DATA_W-1:0] wdata [PORTS],
  output logic [DATA_W-1:0] rdata [PORTS]
);

  logic [DATA_W-1:0] cells [DEPTH];

  // ----------------------------------------------------------------
  // writes and registered reads; the higher port wins a same-cell write
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    for (int p = 0; p < PORTS; p++) begin
      rdata[p] <= cells[addr[p]];
      if (write_en[p]) begin
        cells[addr[p]] <= wdata[p];
      end
    end
  end

endmodule : shared_array
`default_nettype wire

// File: rtl/sram_port_pkg.sv
// constants and carriers shared by the dual-port synchronous ram port logic
package sram_port_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int PORTS = 2;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 9;
  localparam int DEPTH = 131072;

  // ----------------------------------------------------------------
  // counter reset and step, and data reset values
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] LOCATION_ZERO = 17'h00000;
  localparam logic [ADDR_W-1:0] COUNTER_STEP = 17'h00001;
  localparam logic [DATA_W-1:0] DATA_RESET = 9'h000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic read_not_write;
    logic select_active_low;
    logic select_active_high;
    logic address_load_strobe_n;
    logic counter_advance_n;
    logic counter_clear_n;
    logic output_latency_select;
  } port_in_s;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic data_oe_n;
  } port_out_s;

endpackage : sram_port_pkg
